/* File: inc/aso_pkg.sv */
// Constants and types for the sync and override command handler
package aso_pkg;
    localparam int CLOCK_MHZ = 200;
    localparam int SAMPLE_US = 500;
    localparam int SAMPLE_CYCLES = SAMPLE_US * CLOCK_MHZ;
    localparam int TICKS_PER_MS = 1000 / SAMPLE_US;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SYNC_CFG = 5'h04;
    localparam logic [4:0] OFS_POS_VAL = 5'h08;
    localparam logic [4:0] OFS_SPD_VAL = 5'h0C;
    localparam logic [4:0] OFS_STAT_A = 5'h10;
    localparam logic [4:0] OFS_STAT_B = 5'h14;
    localparam logic [4:0] OFS_FOLLOW_SPD = 5'h18;
    localparam int BIT_SYNC = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_SOR = 2;
    localparam int BIT_STOP = 3;
    localparam int BIT_AXIS = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000010F;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [8:0] ERR_NONE = 9'h000;
    localparam logic [8:0] ERR_MCODE = 9'h161;
    localparam logic [8:0] ERR_MASTER = 9'h163;
    localparam logic [8:0] ERR_RATIO = 9'h164;
    localparam logic [8:0] ERR_DELAY = 9'h165;
    localparam logic [8:0] ERR_POR_DWELL = 9'h16A;
    localparam logic [8:0] ERR_SOR_PHASE = 9'h179;
    localparam logic [8:0] ERR_SOR_RANGE = 9'h17A;
    localparam logic [3:0] MASTER_MAX = 4'h9;
    localparam logic [15:0] RATIO_MAX = 16'h2710;
    localparam logic [3:0] DELAY_MAX = 4'hA;
    localparam logic [31:0] SPEED_MAX = 32'h000186A0;
    localparam logic [35:0] RATIO_FULL = 36'h000002710;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ACCEL = 3'b001,
        PH_CONST = 3'b010,
        PH_DECEL = 3'b011,
        PH_DWELL = 3'b100
    } aso_phase_type;
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_ARMED = 2'b01,
        FS_RUN = 2'b10
    } aso_fstate_type;
    typedef struct packed {
        aso_phase_type phase;
        logic reverse;
        logic mcode_on;
        logic [31:0] position;
        logic [31:0] target;
    } aso_axis_in_type;
    typedef struct packed {
        logic valid;
        logic axis;
        logic [31:0] value;
    } aso_cmd_type;
endpackage : aso_pkg

/* File: logic/aso_ctrl.sv */
// Command handler for speed sync start and on-the-fly position and speed override
`timescale 1ns/1ps
module aso_ctrl #(
    parameter int TICK_CYCLES = aso_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Axis state from the motion core, X at index 0, Y at index 1
    input wire aso_pkg::aso_axis_in_type [1:0] axis_in,
    // Master speed magnitudes and directions, X, Y, counters 0 to 7
    input wire logic [9:0][19:0] master_speed,
    input wire logic [9:0] master_reverse,
    // Commands to the motion core
    output aso_pkg::aso_cmd_type target_override,
    output aso_pkg::aso_cmd_type speed_override,
    output logic [1:0] decel_stop,
    // Follower drive
    output logic [1:0] follower_busy,
    output logic follower_run,
    output logic follower_axis,
    output logic follower_reverse,
    output logic [19:0] follower_speed,
    // Request completion
    output logic [2:0] request_done,
    output logic [8:0] sync_status,
    output logic [8:0] por_status,
    output logic [8:0] sor_status
);
    import aso_pkg::*;

    logic [31:0] ctrl_ff;
    logic [31:0] sync_cfg_ff;
    logic [31:0] pos_val_ff;
    logic [31:0] spd_val_ff;
    logic [3:0] ctrl_prev_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_en;
    logic [31:0] lane_mask;
    logic [3:0] req_edge;
    logic req_axis;
    logic [3:0] cfg_master;
    logic [3:0] cfg_delay;
    logic [15:0] cfg_ratio;
    aso_fstate_type fstate_ff;
    logic faxis_ff;
    logic [3:0] fmaster_ff;
    logic [15:0] fratio_ff;
    logic [3:0] fdelay_ff;
    logic [19:0] fspeed_ff;
    logic freverse_ff;
    logic [19:0] ftarget_ff;
    logic [4:0] ticks_left_ff;
    logic [16:0] tick_cnt_ff;
    logic tick;
    logic [8:0] nxt_sync_stat;
    logic [8:0] nxt_por_stat;
    logic [8:0] nxt_sor_stat;
    logic por_passed;
    logic [35:0] scaled;
    logic [19:0] nxt_ftarget;
    logic [4:0] ramp_ticks;
    logic signed [20:0] ramp_diff;
    logic signed [20:0] ramp_step;
    logic [8:0] sync_stat_ff;
    logic [8:0] por_stat_ff;
    logic [8:0] sor_stat_ff;
    logic [2:0] done_ff;
    aso_cmd_type tovr_ff;
    aso_cmd_type sovr_ff;
    logic [1:0] dstop_ff;
    aso_axis_in_type sel_axis;
    logic [1:0] busy_ff;
    logic run_ff;
    logic [4:0] ramp_full;

    // Bus decode and byte lane write mask
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
        end
    endgenerate

    // One wait state; ack drops in the cycle after it is given
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
        end
    end

    // Writes land on the edge that raises ack; the control word keeps its defined bits only
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_ff <= RST_WORD;
            sync_cfg_ff <= RST_WORD;
            pos_val_ff <= RST_WORD;
            spd_val_ff <= RST_WORD;
        end else if (wr_en) begin
            if ({wb_adr_i, 2'b00} == OFS_CTRL) begin
                ctrl_ff <= ((ctrl_ff & ~lane_mask) | (wb_dat_i & lane_mask)) & CTRL_MASK;
            end else if ({wb_adr_i, 2'b00} == OFS_SYNC_CFG) begin
                sync_cfg_ff <= (sync_cfg_ff & ~lane_mask) | (wb_dat_i & lane_mask);
            end else if ({wb_adr_i, 2'b00} == OFS_POS_VAL) begin
                pos_val_ff <= (pos_val_ff & ~lane_mask) | (wb_dat_i & lane_mask);
            end else if ({wb_adr_i, 2'b00} == OFS_SPD_VAL) begin
                spd_val_ff <= (spd_val_ff & ~lane_mask) | (wb_dat_i & lane_mask);
            end
        end
    end

    always_comb begin
        nxt_rdata = RST_WORD;
        if ({wb_adr_i, 2'b00} == OFS_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if ({wb_adr_i, 2'b00} == OFS_SYNC_CFG) begin
            nxt_rdata = sync_cfg_ff;
        end else if ({wb_adr_i, 2'b00} == OFS_POS_VAL) begin
            nxt_rdata = pos_val_ff;
        end else if ({wb_adr_i, 2'b00} == OFS_SPD_VAL) begin
            nxt_rdata = spd_val_ff;
        end else if ({wb_adr_i, 2'b00} == OFS_STAT_A) begin
            nxt_rdata = {7'h00, por_stat_ff, 7'h00, sync_stat_ff};
        end else if ({wb_adr_i, 2'b00} == OFS_STAT_B) begin
            nxt_rdata = {13'h0000, faxis_ff, fstate_ff, 7'h00, sor_stat_ff};
        end else if ({wb_adr_i, 2'b00} == OFS_FOLLOW_SPD) begin
            nxt_rdata = {11'h000, freverse_ff, fspeed_ff};
        end
    end

    // Read data is registered so that it stands in the ack cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_ff <= RST_WORD;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Request bits are levels; an action fires on their rising edge
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_prev_ff <= 4'h0;
        end else begin
            ctrl_prev_ff <= ctrl_ff[3:0];
        end
    end

    assign req_edge = ctrl_ff[3:0] & ~ctrl_prev_ff;
    assign req_axis = ctrl_ff[BIT_AXIS];
    assign cfg_master = sync_cfg_ff[3:0];
    assign cfg_delay = sync_cfg_ff[11:8];
    assign cfg_ratio = sync_cfg_ff[31:16];
    // Checks and commands look at the axis that the request addresses
    assign sel_axis = axis_in[req_axis];

    // Sync request checks; origin reference is never consulted
    always_comb begin
        nxt_sync_stat = ERR_NONE;
        if (cfg_master > MASTER_MAX) begin
            nxt_sync_stat = ERR_MASTER;
        end else if (cfg_ratio == 16'h0000 || cfg_ratio > RATIO_MAX) begin
            nxt_sync_stat = ERR_RATIO;
        end else if (cfg_delay == 4'h0 || cfg_delay > DELAY_MAX) begin
            nxt_sync_stat = ERR_DELAY;
        end else if (sel_axis.mcode_on) begin
            nxt_sync_stat = ERR_MCODE;
        end
    end

    // A target behind the present position in the travel direction is already passed
    assign por_passed = sel_axis.reverse ?
        ($signed(sel_axis.position) < $signed(pos_val_ff)) :
        ($signed(sel_axis.position) > $signed(pos_val_ff));

    // Position override is refused only while dwelling
    always_comb begin
        nxt_por_stat = ERR_NONE;
        if (sel_axis.phase == PH_DWELL) begin
            nxt_por_stat = ERR_POR_DWELL;
        end
    end

    // Phase refusal takes priority over the speed range check
    always_comb begin
        nxt_sor_stat = ERR_NONE;
        if (sel_axis.phase == PH_DECEL || sel_axis.phase == PH_DWELL) begin
            nxt_sor_stat = ERR_SOR_PHASE;
        end else if (spd_val_ff == RST_WORD || spd_val_ff > SPEED_MAX) begin
            nxt_sor_stat = ERR_SOR_RANGE;
        end
    end

    // Status and done pulses
    // A refused request still pulses done; its status holds the code
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_stat_ff <= ERR_NONE;
            por_stat_ff <= ERR_NONE;
            sor_stat_ff <= ERR_NONE;
            done_ff <= 3'b000;
        end else begin
            done_ff <= req_edge[2:0];
            if (req_edge[BIT_SYNC]) begin
                sync_stat_ff <= nxt_sync_stat;
            end
            if (req_edge[BIT_POR]) begin
                por_stat_ff <= nxt_por_stat;
            end
            if (req_edge[BIT_SOR]) begin
                sor_stat_ff <= nxt_sor_stat;
            end
        end
    end

    // Override commands act on the running step only; no step table is written
    always_ff @(posedge clock) begin
        if (reset) begin
            tovr_ff <= '0;
            sovr_ff <= '0;
            dstop_ff <= 2'b00;
        end else begin
            tovr_ff.valid <= 1'b0;
            sovr_ff.valid <= 1'b0;
            dstop_ff <= 2'b00;
            if (req_edge[BIT_POR] && nxt_por_stat == ERR_NONE && sel_axis.phase != PH_IDLE) begin
                if (por_passed) begin
                    dstop_ff[req_axis] <= 1'b1;
                end else begin
                    tovr_ff.valid <= 1'b1;
                    tovr_ff.axis <= req_axis;
                    tovr_ff.value <= pos_val_ff;
                end
            end
            if (req_edge[BIT_SOR] && nxt_sor_stat == ERR_NONE && sel_axis.phase != PH_IDLE) begin
                sovr_ff.valid <= 1'b1;
                sovr_ff.axis <= req_axis;
                sovr_ff.value <= spd_val_ff;
            end
            // Stop on the follower axis ends sync in the state machine; others get a stop pulse
            if (req_edge[BIT_STOP] && !(fstate_ff != FS_IDLE && faxis_ff == req_axis)) begin
                dstop_ff[req_axis] <= 1'b1;
            end
        end
    end

    // Sampling tick divider
    always_ff @(posedge clock) begin
        if (reset) begin
            tick_cnt_ff <= 17'h00000;
        end else if (tick) begin
            tick_cnt_ff <= 17'h00000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 17'h00001;
        end
    end

    assign tick = (tick_cnt_ff == 17'(TICK_CYCLES - 1));

    // Ratio-scaled master speed, 10000 is full speed
    assign scaled = (36'(master_speed[fmaster_ff]) * 36'(fratio_ff)) / RATIO_FULL;
    assign nxt_ftarget = scaled[19:0];
    // A new target restarts the ramp, spread over the delay counted in ticks
    assign ramp_full = 5'(fdelay_ff) * 5'(TICKS_PER_MS);
    assign ramp_ticks = (nxt_ftarget != ftarget_ff) ? ramp_full : ticks_left_ff;
    assign ramp_diff = $signed({1'b0, nxt_ftarget}) - $signed({1'b0, fspeed_ff});
    assign ramp_step = ramp_diff / $signed({16'h0000, ramp_ticks});

    // Follower state machine
    always_ff @(posedge clock) begin
        if (reset) begin
            fstate_ff <= FS_IDLE;
            faxis_ff <= 1'b0;
            fmaster_ff <= 4'h0;
            fratio_ff <= 16'h0000;
            fdelay_ff <= 4'h0;
        end else begin
            case (fstate_ff)
                FS_IDLE: begin
                    if (req_edge[BIT_SYNC] && nxt_sync_stat == ERR_NONE) begin
                        fstate_ff <= FS_ARMED;
                        faxis_ff <= req_axis;
                        fmaster_ff <= cfg_master;
                        fratio_ff <= cfg_ratio;
                        fdelay_ff <= cfg_delay;
                    end
                end
                FS_ARMED: begin
                    // Any motion of the chosen master releases the armed follower
                    if (req_edge[BIT_STOP] && req_axis == faxis_ff) begin
                        fstate_ff <= FS_IDLE;
                    end else if (master_speed[fmaster_ff] != 20'h00000) begin
                        fstate_ff <= FS_RUN;
                    end
                end
                FS_RUN: begin
                    if (req_edge[BIT_STOP] && req_axis == faxis_ff) begin
                        fstate_ff <= FS_IDLE;
                    end
                end
                default: begin
                    fstate_ff <= FS_IDLE;
                end
            endcase
        end
    end

    // Speed ramp toward the scaled master speed, spread over the delay
    always_ff @(posedge clock) begin
        if (reset) begin
            fspeed_ff <= 20'h00000;
            ftarget_ff <= 20'h00000;
            ticks_left_ff <= 5'h01;
            freverse_ff <= 1'b0;
        end else if (fstate_ff != FS_RUN) begin
            // Outside run the speed rests at zero, so each start ramps from rest
            fspeed_ff <= 20'h00000;
            ftarget_ff <= 20'h00000;
            ticks_left_ff <= 5'h01;
        end else if (tick) begin
            ftarget_ff <= nxt_ftarget;
            fspeed_ff <= 20'($signed({1'b0, fspeed_ff}) + ramp_step);
            ticks_left_ff <= (ramp_ticks > 5'h01) ? ramp_ticks - 5'h01 : 5'h01;
            freverse_ff <= master_reverse[fmaster_ff];
        end
    end

    // Busy and run leave through their own flops, one cycle behind the state
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_ff <= 2'b00;
            run_ff <= 1'b0;
        end else begin
            busy_ff <= 2'b00;
            if (fstate_ff != FS_IDLE) begin
                busy_ff[faxis_ff] <= 1'b1;
            end
            run_ff <= (fstate_ff == FS_RUN);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign target_override = tovr_ff;
    assign speed_override = sovr_ff;
    assign decel_stop = dstop_ff;
    // In-operation flag of the follower holds while armed or running
    assign follower_busy = busy_ff;
    assign follower_run = run_ff;
    assign follower_axis = faxis_ff;
    assign follower_reverse = freverse_ff;
    assign follower_speed = fspeed_ff;
    assign request_done = done_ff;
    assign sync_status = sync_stat_ff;
    assign por_status = por_stat_ff;
    assign sor_status = sor_stat_ff;
endmodule : aso_ctrl

/* File: verification/aso_ctrl_checker.sv */
// Concurrent checks on the ports of the sync and override command handler
`timescale 1ns/1ps
module aso_ctrl_checker (
    // Clock, reset and bus
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Axis state and commands
    input wire aso_pkg::aso_axis_in_type [1:0] axis_in,
    input wire aso_pkg::aso_cmd_type target_override,
    input wire aso_pkg::aso_cmd_type speed_override,
    input wire logic [1:0] decel_stop,
    // Follower and completion
    input wire logic [1:0] follower_busy,
    input wire logic follower_run,
    input wire logic follower_axis,
    input wire logic [19:0] follower_speed,
    input wire logic [2:0] request_done,
    input wire logic [8:0] sync_status,
    input wire logic [8:0] por_status,
    input wire logic [8:0] sor_status
);
    import aso_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus access not answered after one wait state");
    a_done_pulse: assert property (request_done != 3'h0 |=> request_done == 3'h0)
        else $error("done held longer than one cycle");
    a_por_cmd: assert property (target_override.valid |-> request_done[1] && por_status == 9'h000)
        else $error("target command without clean completion");
    a_por_phase: assert property (target_override.valid |->
        (target_override.axis ? $past(axis_in[1].phase) : $past(axis_in[0].phase))
        inside {PH_ACCEL, PH_CONST, PH_DECEL})
        else $error("target command outside a motion phase");
    a_por_dwell: assert property (request_done[1] && por_status == 9'h16A |->
        !target_override.valid && decel_stop == 2'h0)
        else $error("refused target override still acted");
    a_sor_phase: assert property (speed_override.valid |->
        request_done[2] && sor_status == 9'h000 &&
        (speed_override.axis ? $past(axis_in[1].phase) : $past(axis_in[0].phase))
        inside {PH_ACCEL, PH_CONST})
        else $error("speed command in a refused phase");
    a_sor_range: assert property (speed_override.valid |->
        speed_override.value inside {[32'h00000001:32'h000186A0]})
        else $error("speed command out of range");
    a_armed_still: assert property (follower_busy != 2'h0 && !follower_run |->
        follower_speed == 20'h00000)
        else $error("armed follower has a speed");
    a_run_busy: assert property (follower_run |-> follower_busy[follower_axis])
        else $error("running follower without busy flag");
    a_status_hold: assert property (!request_done[0] |-> $stable(sync_status))
        else $error("sync status changed without a request");
    c_target: cover property (target_override.valid);
    c_decel: cover property (decel_stop != 2'h0);
    c_follow: cover property (follower_run);
endmodule : aso_ctrl_checker

/* File: verification/aso_motion_model.sv */
// Motion core stand-in that moves both axes and supplies master speeds
`timescale 1ns/1ps
module aso_motion_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Requested phase, direction and M code per axis
    input wire logic [1:0][2:0] phase_req,
    input wire logic [1:0] rev_req,
    input wire logic [1:0] mcode_req,
    // Commands from the handler
    input wire aso_pkg::aso_cmd_type target_override,
    input wire logic [1:0] decel_stop,
    // State back to the handler
    output aso_pkg::aso_axis_in_type [1:0] axis_in,
    output logic [9:0][19:0] master_speed,
    output logic [9:0] master_reverse
);
    import aso_pkg::*;
    logic [1:0] stop_ff;
    logic [1:0] moving;
    logic [1:0][31:0] pos_ff;
    logic [1:0][31:0] tgt_ff;
    always_comb begin
        master_speed = '0;
        master_reverse = {8'h00, rev_req};
        for (int a = 0; a < 2; a++) begin
            moving[a] = phase_req[a] inside {3'h1, 3'h2, 3'h3};
            axis_in[a].phase = stop_ff[a] && moving[a] ? PH_DECEL : aso_phase_type'(phase_req[a]);
            axis_in[a].reverse = rev_req[a];
            axis_in[a].mcode_on = mcode_req[a];
            axis_in[a].position = pos_ff[a];
            axis_in[a].target = tgt_ff[a];
            master_speed[a] = moving[a] ? 20'h003E8 : 20'h00000;
        end
    end
    // A stop order holds the axis in deceleration until it leaves motion
    always_ff @(posedge clock) begin
        for (int a = 0; a < 2; a++) begin
            if (reset || !moving[a]) stop_ff[a] <= 1'b0;
            else if (decel_stop[a]) stop_ff[a] <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        for (int a = 0; a < 2; a++) begin
            if (reset) begin
                pos_ff[a] <= 32'h0;
                tgt_ff[a] <= 32'h0;
            end else begin
                if (moving[a]) pos_ff[a] <= rev_req[a] ? pos_ff[a] - 32'h1 : pos_ff[a] + 32'h1;
                if (target_override.valid && target_override.axis == a[0]) begin
                    tgt_ff[a] <= target_override.value;
                end
            end
        end
    end
endmodule : aso_motion_model

/* File: verification/tb_axis_sync_and_override_ctrl.sv */
// Self-checking testbench for the sync and override command handler
`timescale 1ns/1ps
module tb_axis_sync_and_override_ctrl;
    import aso_pkg::*;
    localparam int TICK = 50;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [4:2] wb_adr_i = 3'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [1:0][2:0] phase_req = 6'h00;
    logic [1:0] rev_req = 2'h0, mcode_req = 2'h0, decel_stop, follower_busy, got_stop;
    aso_axis_in_type [1:0] axis_in;
    logic [9:0][19:0] master_speed;
    logic [9:0] master_reverse;
    aso_cmd_type target_override, speed_override, got_tgt, got_spd;
    logic follower_run, follower_axis, follower_reverse;
    logic [19:0] follower_speed;
    logic [2:0] request_done;
    logic [8:0] sync_status, por_status, sor_status, got_st;
    int bad_count = 0, n_compared = 0, cycles = 0;
    always #2.5 clock = ~clock;
    aso_motion_model mdl_u (.clock, .reset, .phase_req, .rev_req, .mcode_req, .target_override,
        .decel_stop, .axis_in, .master_speed, .master_reverse);
    aso_ctrl #(.TICK_CYCLES(TICK)) dut_u (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .axis_in, .master_speed,
        .master_reverse, .target_override, .speed_override, .decel_stop, .follower_busy,
        .follower_run, .follower_axis, .follower_reverse, .follower_speed, .request_done,
        .sync_status, .por_status, .sor_status);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s %0h not %0h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a[4:2];
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    // Raises one request bit, gathers what answers it, then lowers the bit
    task automatic req(input int b, input logic ax);
        got_st = 9'h1FF;
        got_tgt = '0;
        got_spd = '0;
        got_stop = 2'h0;
        wb(1'b1, OFS_CTRL, (32'h1 << b) | {23'h0, ax, 8'h00});
        repeat (8) begin
            @(posedge clock);
            got_stop = got_stop | decel_stop;
            if (b < 3 && request_done[b] === 1'b1) begin
                got_tgt = target_override;
                got_spd = speed_override;
                got_st = (b == 0) ? sync_status : (b == 1) ? por_status : sor_status;
            end
        end
        wb(1'b1, OFS_CTRL, {23'h0, ax, 8'h00});
    endtask : req
    task automatic t_reset();
        wb(1'b1, 5'h1C, 32'hFFFFFFFF);
        wb(1'b0, 5'h1C, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b0, OFS_STAT_A, 32'h0);
        chk(rd, 32'h0, "status at reset");
    endtask : t_reset
    task automatic t_sync_refuse();
        logic [31:0] cfg [7] = '{32'h1388010A, 32'h00000100, 32'h27110100, 32'h13880000,
            32'h13880B00, 32'h27100A09, 32'h00010101};
        logic [8:0] code [7] = '{9'h163, 9'h164, 9'h164, 9'h165, 9'h165, 9'h000, 9'h000};
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, OFS_SYNC_CFG, cfg[i]);
            req(0, 1'b0);
            chk(got_st, code[i], "sync status");
            chk(follower_busy[0], code[i] == 9'h000, "armed flag");
            if (code[i] == 9'h000) req(3, 1'b0);
        end
        mcode_req[1] <= 1'b1;
        req(0, 1'b1);
        chk(got_st, 9'h161, "M code status");
        mcode_req[1] <= 1'b0;
    endtask : t_sync_refuse
    task automatic t_sync_run();
        rev_req[0] <= 1'b1;
        wb(1'b1, OFS_SYNC_CFG, 32'h13880200);
        req(0, 1'b1);
        chk(got_st, 9'h000, "sync accepted");
        chk({follower_busy, follower_run, follower_speed}, 23'h400000, "armed");
        phase_req[0] <= 3'h2;
        repeat (TICK * 3) @(posedge clock);
        chk(follower_speed > 20'h0 && follower_speed < 20'h001F4, 1'b1, "ramping");
        repeat (TICK * 3) @(posedge clock);
        chk({follower_run, follower_axis, follower_reverse, follower_speed}, 23'h7001F4,
            "synced");
        req(0, 1'b1);
        chk(follower_run, 1'b1, "second sync edge");
        phase_req[0] <= 3'h0;
        rev_req[0] <= 1'b0;
        req(3, 1'b1);
        chk({follower_busy, follower_speed}, 22'h0, "cancelled");
    endtask : t_sync_run
    task automatic t_por();
        logic [31:0] pv [4] = '{32'h7FFFFFFF, 32'h80000000, 32'h7FFFFFFF, 32'h7FFFFFFF};
        logic [2:0] exp [4] = '{3'h4, 3'h1, 3'h4, 3'h0};
        phase_req[0] <= 3'h2;
        repeat (20) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) phase_req[0] <= 3'h4;
            wb(1'b1, OFS_POS_VAL, pv[i]);
            req(1, 1'b0);
            chk(got_st, i == 3 ? 9'h16A : 9'h000, "override status");
            chk({got_tgt.valid, got_stop}, exp[i], "override command");
            if (exp[i][2]) chk(got_tgt.value, pv[i], "new target");
        end
    endtask : t_por
    task automatic t_sor();
        logic [2:0] ph [5] = '{3'h2, 3'h1, 3'h2, 3'h3, 3'h4};
        logic [31:0] sv [5] = '{32'h2710, 32'h186A0, 32'h0, 32'h2710, 32'h2710};
        logic [8:0] st [5] = '{9'h000, 9'h000, 9'h17A, 9'h179, 9'h179};
        for (int i = 0; i < 5; i++) begin
            phase_req[0] <= ph[i];
            wb(1'b1, OFS_SPD_VAL, sv[i]);
            req(2, 1'b0);
            chk(got_st, st[i], "speed status");
            chk(got_spd.valid, st[i] == 9'h000, "speed command");
            if (st[i] == 9'h000) chk(got_spd.value, sv[i], "new speed");
        end
        phase_req[0] <= 3'h0;
    endtask : t_sor
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_sync_refuse();
        t_sync_run();
        t_por();
        t_sor();
        print_verdict();
    end
endmodule : tb_axis_sync_and_override_ctrl
bind aso_ctrl aso_ctrl_checker chk_u (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .axis_in,
    .target_override, .speed_override, .decel_stop, .follower_busy, .follower_run, .follower_axis,
    .follower_speed, .request_done, .sync_status, .por_status, .sor_status);
